// >>> core/pcda_core.sv
`timescale 1ns/1ps
module pcda_core #(
	parameter int RAW_PER_REV = 1280000,
	parameter int PULSE_CYC   = pcda_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// Register port
	input  wire pcda_pkg::pcda_req_t        req,
	output logic [pcda_pkg::DATA_W-1:0]     rdata,
	// Motor encoder raw increments
	input  wire pcda_pkg::pcda_enc_t        enc,
	// Compare output and nonvolatile store request
	output logic                            compare_output_pin,
	output logic                            nvm_store_req
);
	import pcda_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic signed [DATA_W-1:0] arr_mem [ARR_DEPTH];
	logic [DATA_W-1:0] ctrl_q, ppr_q, gear_num_q, gear_den_q;
	logic [IDX_W-1:0]  cmp_start_q, cmp_count_q, cap_start_q, cap_count_q, cam_start_q, cam_count_q;
	logic [IDX_W-1:0]  rd_index_q, wr_index_q, ptr_q, remain_q;
	logic signed [DATA_W-1:0] counter_q, enc_pos_q, target_q;
	logic [31:0]       acc_q, pulse_cnt_q;
	pcda_state_t       state_q;

	wire wr_en    = req.wr;
	wire rd_en    = req.rd;
	wire wr_ctrl  = wr_en && req.addr == REG_CTRL;
	wire arm_load = wr_ctrl && ctrl_q[CTRL_SRC_LSB+:4] == SRC_IDLE
	                && req.wdata[CTRL_SRC_LSB+:4] == SRC_MAIN_ENC;
	wire enabled  = ctrl_q[CTRL_EN_BIT];
	wire match    = state_q == PCDA_ARM && counter_q == target_q;
	wire last     = match && remain_q <= CNT_RST;

	// ------------------------------------------------------------
	// Encoder scaling: output pulses per rev, times four
	// ------------------------------------------------------------
	logic [32:0] acc_sum;
	logic        enc_cnt;
	always_comb begin
		acc_sum = {1'b0, acc_q} + {ppr_q[30:0], 2'b00};
		enc_cnt = enc.step && acc_sum >= 33'(RAW_PER_REV);
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q)
			acc_q <= 32'h0000_0000;
		else if (enc_cnt)
			acc_q <= 32'(acc_sum - 33'(RAW_PER_REV));
		else if (enc.step)
			acc_q <= acc_sum[31:0];
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q)
			enc_pos_q <= 32'h0000_0000;
		else if (enc_cnt)
			enc_pos_q <= enc.dir ? enc_pos_q - 32'sh1 : enc_pos_q + 32'sh1;
	end

	// ------------------------------------------------------------
	// Compare position counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q)
			counter_q <= 32'h0000_0000;
		else if (arm_load)
			counter_q <= enc_pos_q;
		else if (last && ctrl_q[CTRL_CLEAR_BIT])
			counter_q <= 32'h0000_0000;
		else if (wr_en && req.addr == REG_CMP_CNTR)
			counter_q <= req.wdata;
		else if (enc_cnt)
			counter_q <= enc.dir ? counter_q - 32'sh1 : counter_q + 32'sh1;
	end

	// ------------------------------------------------------------
	// Compare sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q  <= PCDA_IDLE;
			ptr_q    <= 10'h000;
			remain_q <= 10'h000;
			target_q <= 32'h0000_0000;
		end else if (arm_load || (wr_ctrl && req.wdata[CTRL_EN_BIT] && !enabled)) begin
			state_q  <= PCDA_FETCH;
			ptr_q    <= cmp_start_q;
			remain_q <= cmp_count_q;
		end else if (wr_ctrl && !req.wdata[CTRL_EN_BIT]) begin
			state_q <= PCDA_IDLE;
		end else begin
			unique case (state_q)
				PCDA_IDLE: begin
				end
				PCDA_FETCH: begin
					target_q <= arr_mem[ptr_q];
					state_q  <= remain_q == 10'h000 ? PCDA_IDLE : PCDA_ARM;
				end
				PCDA_ARM: begin
					if (last && ctrl_q[CTRL_REPEAT_BIT]) begin
						remain_q <= cmp_count_q;
						ptr_q    <= cmp_start_q;
						state_q  <= PCDA_FETCH;
					end else if (last) begin
						remain_q <= 10'h000;
						state_q  <= PCDA_IDLE;
					end else if (match) begin
						remain_q <= remain_q - 10'h001;
						ptr_q    <= pcda_idx_add(ptr_q, 2'd1);
						state_q  <= PCDA_FETCH;
					end
				end
				default: state_q <= PCDA_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output pulse stretcher
	// ------------------------------------------------------------
	logic [31:0] width_cyc;
	always_comb begin
		width_cyc = 32'(ctrl_q[CTRL_WIDTH_LSB+:8]) * 32'(PULSE_CYC);
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pulse_cnt_q        <= 32'h0000_0000;
			compare_output_pin <= 1'b0;
		end else if (match) begin
			pulse_cnt_q        <= width_cyc;
			compare_output_pin <= 1'b1;
		end else if (pulse_cnt_q > 32'h0000_0001) begin
			pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
		end else begin
			pulse_cnt_q        <= 32'h0000_0000;
			compare_output_pin <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q      <= CTRL_RST;
			ppr_q       <= PPR_RST;
			gear_num_q  <= 32'h0000_0001;
			gear_den_q  <= 32'h0000_0001;
			cmp_start_q <= 10'h000;
			cmp_count_q <= CNT_RST;
			cap_start_q <= 10'h000;
			cap_count_q <= CNT_RST;
			cam_start_q <= 10'h000;
			cam_count_q <= CNT_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= req.wdata | (arm_load ? 32'h0000_0001 : 32'h0000_0000);
			else if (last && !ctrl_q[CTRL_REPEAT_BIT])
				ctrl_q[CTRL_EN_BIT] <= 1'b0;
			if (wr_en) begin
				unique case (req.addr)
					REG_PPR:       ppr_q       <= req.wdata;
					REG_GEAR_NUM:  gear_num_q  <= req.wdata;
					REG_GEAR_DEN:  gear_den_q  <= req.wdata;
					REG_CMP_START: cmp_start_q <= req.wdata[IDX_W-1:0];
					REG_CMP_COUNT: cmp_count_q <= req.wdata[IDX_W-1:0];
					REG_CAP_START: cap_start_q <= req.wdata[IDX_W-1:0];
					REG_CAP_COUNT: cap_count_q <= req.wdata[IDX_W-1:0];
					REG_CAM_START: cam_start_q <= req.wdata[IDX_W-1:0];
					REG_CAM_COUNT: cam_count_q <= req.wdata[IDX_W-1:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Data array access
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (wr_en && req.addr == REG_WR_DATA && wr_index_q <= IDX_LAST)
			arr_mem[wr_index_q] <= req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_index_q <= 10'h000;
			rd_index_q <= 10'h000;
		end else begin
			if (wr_en && req.addr == REG_WR_INDEX)
				wr_index_q <= req.wdata[IDX_W-1:0] > IDX_LAST ? IDX_LAST : req.wdata[IDX_W-1:0];
			else if (wr_en && req.addr == REG_WR_DATA)
				wr_index_q <= pcda_idx_add(wr_index_q, 2'd1);
			if (wr_en && req.addr == REG_RD_INDEX)
				rd_index_q <= req.wdata[IDX_W-1:0] > IDX_LAST ? IDX_LAST : req.wdata[IDX_W-1:0];
			else if (rd_en && req.addr == REG_RD_WIN2)
				rd_index_q <= pcda_idx_add(rd_index_q, 2'd2);
		end
	end

	// Store allowed only while the compare enable bit is clear
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q)
			nvm_store_req <= 1'b0;
		else
			nvm_store_req <= wr_en && req.addr == REG_NVM_CMD && req.wdata[0] && !enabled;
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata <= 32'h0000_0000;
		end else if (!rd_en) begin
			rdata <= 32'h0000_0000;
		end else begin
			unique case (req.addr)
				REG_CTRL:      rdata <= ctrl_q;
				REG_CMP_START: rdata <= {22'h000000, cmp_start_q};
				REG_CMP_COUNT: rdata <= {22'h000000, remain_q};
				REG_CMP_CNTR:  rdata <= counter_q;
				REG_CAP_START: rdata <= {22'h000000, cap_start_q};
				REG_CAP_COUNT: rdata <= {22'h000000, cap_count_q};
				REG_CAM_START: rdata <= {22'h000000, cam_start_q};
				REG_CAM_COUNT: rdata <= {22'h000000, cam_count_q};
				REG_PPR:       rdata <= ppr_q;
				REG_GEAR_NUM:  rdata <= gear_num_q;
				REG_GEAR_DEN:  rdata <= gear_den_q;
				REG_RD_INDEX:  rdata <= {22'h000000, rd_index_q};
				REG_RD_WIN1:   rdata <= arr_mem[rd_index_q];
				REG_RD_WIN2:   rdata <= arr_mem[pcda_idx_add(rd_index_q, 2'd1)];
				REG_WR_INDEX:  rdata <= {22'h000000, wr_index_q};
				REG_ENC_POS:   rdata <= enc_pos_q;
				REG_STATUS:    rdata <= {30'h00000000, state_q};
				default:       rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// >>> shared/pcda_pkg.sv
package pcda_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int          ARR_DEPTH    = 800;
	localparam int          IDX_W        = 10;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          CLK_HZ       = 40000000;
	localparam int          PULSE_UNIT_MS = 1;
	localparam int          CYC_PER_MS   = CLK_HZ / 1000 * PULSE_UNIT_MS;
	localparam logic [IDX_W-1:0] IDX_LAST = 10'h31f;

	// ------------------------------------------------------------
	// Register word offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CMP_START = 8'h01;
	localparam logic [ADDR_W-1:0] REG_CMP_COUNT = 8'h02;
	localparam logic [ADDR_W-1:0] REG_CMP_CNTR = 8'h03;
	localparam logic [ADDR_W-1:0] REG_CAP_START = 8'h04;
	localparam logic [ADDR_W-1:0] REG_CAP_COUNT = 8'h05;
	localparam logic [ADDR_W-1:0] REG_CAM_START = 8'h06;
	localparam logic [ADDR_W-1:0] REG_CAM_COUNT = 8'h07;
	localparam logic [ADDR_W-1:0] REG_PPR      = 8'h08;
	localparam logic [ADDR_W-1:0] REG_GEAR_NUM = 8'h09;
	localparam logic [ADDR_W-1:0] REG_GEAR_DEN = 8'h0a;
	localparam logic [ADDR_W-1:0] REG_RD_INDEX = 8'h0b;
	localparam logic [ADDR_W-1:0] REG_RD_WIN1  = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_RD_WIN2  = 8'h0d;
	localparam logic [ADDR_W-1:0] REG_WR_INDEX = 8'h0e;
	localparam logic [ADDR_W-1:0] REG_WR_DATA  = 8'h0f;
	localparam logic [ADDR_W-1:0] REG_NVM_CMD  = 8'h10;
	localparam logic [ADDR_W-1:0] REG_ENC_POS  = 8'h11;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h12;

	// ------------------------------------------------------------
	// Control field layout and reset values
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_REPEAT_BIT = 1;
	localparam int CTRL_CLEAR_BIT  = 3;
	localparam int CTRL_SRC_LSB    = 4;
	localparam int CTRL_WIDTH_LSB  = 16;
	localparam logic [3:0]  SRC_IDLE     = 4'h0;
	localparam logic [3:0]  SRC_MAIN_ENC = 4'h3;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] PPR_RST      = 32'h0000_2710;
	localparam logic [IDX_W-1:0] CNT_RST = 10'h001;

	typedef enum logic [1:0] {
		PCDA_IDLE  = 2'b00,
		PCDA_FETCH = 2'b01,
		PCDA_ARM   = 2'b10
	} pcda_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pcda_req_t;

	typedef struct packed {
		logic step;
		logic dir;
	} pcda_enc_t;

	function automatic logic [IDX_W-1:0] pcda_idx_add(input logic [IDX_W-1:0] idx, input logic [1:0] inc);
		logic [IDX_W:0] s;
		s = {1'b0, idx} + {9'h000, inc};
		if (s > {1'b0, IDX_LAST})
			s = s - 11'(ARR_DEPTH);
		return s[IDX_W-1:0];
	endfunction
endpackage

// >>> sim/pcda_enc_model.sv
`timescale 1ns/1ps
module pcda_enc_model (
	// Clock
	input wire logic            clk,
	// Raw increments toward the core
	output pcda_pkg::pcda_enc_t enc
);
	import pcda_pkg::*;
	initial enc = '0;
	// One raw increment per call step; gap sets a slow motor
	task automatic move(input int n, input logic down, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			enc <= '{step: 1'b1, dir: down};
			@(posedge clk);
			enc <= '{step: 1'b0, dir: ~down};
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule

// >>> sim/pcda_props.sv
`timescale 1ns/1ps
module pcda_props #(
	parameter int RAW_PER_REV = 1280000,
	parameter int PULSE_CYC   = pcda_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        rstn,
	// Register port
	input wire pcda_pkg::pcda_req_t         req,
	input wire logic [pcda_pkg::DATA_W-1:0] rdata,
	// Encoder and outputs
	input wire pcda_pkg::pcda_enc_t         enc,
	input wire logic                        compare_output_pin,
	input wire logic                        nvm_store_req
);
	import pcda_pkg::*;
	logic [31:0] shadow_q [16];
	logic [15:0] known_q;
	logic [7:0]  width_q;
	logic [31:0] hi_cnt_q;
	logic [5:0]  cause_q;
	logic [2:0]  nvm_wr_q;
	logic [31:0] pulse_len;
	// Plain read-write registers mirrored here
	function automatic logic tracked(input logic [ADDR_W-1:0] a);
		return a inside {REG_CMP_START, REG_CAP_START, REG_CAP_COUNT, REG_CAM_START, REG_CAM_COUNT, REG_PPR,
			REG_GEAR_NUM, REG_GEAR_DEN};
	endfunction
	assign pulse_len = (width_q == 8'h00) ? 32'h0000_0001 : 32'(width_q) * 32'(PULSE_CYC);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			known_q     <= 16'h0100;
			shadow_q[8] <= PPR_RST;
		end else if (req.wr && tracked(req.addr)) begin
			known_q[req.addr[3:0]]  <= 1'b1;
			shadow_q[req.addr[3:0]] <= req.wdata;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			width_q  <= 8'h00;
			hi_cnt_q <= 32'h0000_0000;
			cause_q  <= 6'h00;
			nvm_wr_q <= 3'h0;
		end else begin
			if (req.wr && req.addr == REG_CTRL)
				width_q <= req.wdata[23:16];
			hi_cnt_q <= compare_output_pin ? hi_cnt_q + 32'h0000_0001 : 32'h0000_0000;
			cause_q  <= {cause_q[4:0], enc.step | req.wr};
			nvm_wr_q <= {nvm_wr_q[1:0], req.wr && req.addr == REG_NVM_CMD && req.wdata[0]};
		end
	end
	AST_RD_IDLE_ZERO: assert property (!$past(req.rd) |-> rdata == '0)
		else $error("read data not zero outside a read answer");
	AST_UNMAPPED_ZERO: assert property ($past(req.rd) && $past(req.addr) > REG_STATUS |-> rdata == '0)
		else $error("unmapped read returned data");
	AST_RESET_QUIET: assert property ($rose(rstn) |-> !compare_output_pin && !nvm_store_req ##1 !compare_output_pin)
		else $error("output active right after reset");
	AST_READBACK: assert property ($past(req.rd) && tracked($past(req.addr)) && known_q[$past(req.addr[3:0])]
		|-> rdata == shadow_q[$past(req.addr[3:0])]) else $error("register read back differs");
	AST_PULSE_WIDTH: assert property ($fell(compare_output_pin) |-> hi_cnt_q == pulse_len)
		else $error("compare pulse length wrong");
	AST_PIN_CAUSE: assert property ($rose(compare_output_pin) |-> cause_q != 6'h00)
		else $error("compare pulse without step or write");
	AST_NVM_ONE_CYCLE: assert property (nvm_store_req |=> !nvm_store_req)
		else $error("store request longer than one cycle");
	AST_NVM_CAUSE: assert property (nvm_store_req |-> nvm_wr_q != 3'h0)
		else $error("store request without command");
	COV_PIN: cover property ($rose(compare_output_pin));
	COV_NVM: cover property (nvm_store_req);
	COV_UNMAPPED: cover property ($past(req.rd) && $past(req.addr) > REG_STATUS);
endmodule
bind pcda_core pcda_props #(.RAW_PER_REV(RAW_PER_REV), .PULSE_CYC(PULSE_CYC)) u_pcda_props (.clk(clk), .rstn(rstn),
	.req(req), .rdata(rdata), .enc(enc), .compare_output_pin(compare_output_pin), .nvm_store_req(nvm_store_req));

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pcda_pkg::*;
	// ------------------------------------------------------------
	// Harness
	// ------------------------------------------------------------
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	pcda_req_t         req = '0;
	logic [DATA_W-1:0] rdata;
	pcda_enc_t         enc;
	logic              pin, nvm, pin_q = 1'b0;
	int                num_errors = 0, n_compared = 0, n_pulse = 0, n_nvm = 0;
	localparam logic [ADDR_W-1:0] RA [5] = '{REG_CMP_START, REG_CAP_START, REG_CAP_COUNT, REG_CAM_START, REG_CAM_COUNT};
	always #12.5 clk = ~clk;
	pcda_core #(.RAW_PER_REV(40), .PULSE_CYC(4)) u_pcda_core (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
		.enc(enc), .compare_output_pin(pin), .nvm_store_req(nvm));
	pcda_enc_model u_pcda_enc_model (.clk(clk), .enc(enc));
	always @(posedge clk) begin
		pin_q <= pin;
		if (pin === 1'b1 && pin_q === 1'b0) n_pulse++;
		if (nvm === 1'b1) n_nvm++;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
		@(posedge clk);
		req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] q;
		rd(a, q);
		chk(q, e);
	endtask
	// Motion, then time for the last pulse to end
	task automatic go(input int n, input logic down, input int gap);
		u_pcda_enc_model.move(n, down, gap);
		repeat (12) @(posedge clk);
	endtask
	// Source digit 0 then 3 with repeat and clear
	task automatic load();
		wr(REG_CMP_COUNT, 32'h2);
		wr(REG_CTRL, 32'h0002_000a);
		wr(REG_CTRL, 32'h0002_003b);
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rc(REG_PPR, PPR_RST);
		for (int i = 0; i < 5; i++) wr(RA[i], 32'(50 + 9 * i));
		for (int i = 0; i < 5; i++) rc(RA[i], 32'(50 + 9 * i));
		rc(8'h3f, 32'h0);
		wr(REG_RD_INDEX, 32'h3e8);
		rc(REG_RD_INDEX, 32'h31f);
		$display("test registers done");
		wr(REG_WR_INDEX, 32'h31e);
		wr(REG_WR_DATA, 32'h8000_0001);
		wr(REG_WR_DATA, 32'h1234_5678);
		wr(REG_WR_INDEX, 32'h32);
		wr(REG_WR_DATA, 32'h5);
		wr(REG_WR_DATA, 32'ha);
		rc(REG_WR_INDEX, 32'h34);
		wr(REG_RD_INDEX, 32'h31e);
		rc(REG_RD_WIN1, 32'h8000_0001);
		rc(REG_RD_WIN2, 32'h1234_5678);
		rc(REG_RD_INDEX, 32'h0);
		wr(REG_RD_INDEX, 32'h32);
		rc(REG_RD_WIN1, 32'h5);
		rc(REG_RD_WIN2, 32'ha);
		$display("test array done");
		wr(REG_PPR, 32'h5);
		wr(REG_GEAR_NUM, 32'h3);
		wr(REG_GEAR_DEN, 32'h7);
		rc(REG_GEAR_DEN, 32'h7);
		wr(REG_CMP_COUNT, 32'h2);
		wr(REG_CMP_CNTR, 32'h0);
		wr(REG_CTRL, 32'h0002_0001);
		go(24, 1'b0, 0);
		chk(n_pulse, 2);
		rc(REG_CMP_CNTR, 32'hc);
		rc(REG_CMP_COUNT, 32'h0);
		rc(REG_STATUS, 32'h0);
		$display("test single pass done");
		n_pulse = 0;
		wr(REG_CMP_COUNT, 32'h2);
		wr(REG_CMP_CNTR, 32'h0);
		wr(REG_CTRL, 32'h0002_000b);
		go(24, 1'b0, 3);
		chk(n_pulse, 2);
		rc(REG_CMP_CNTR, 32'h2);
		rc(REG_CMP_COUNT, 32'h2);
		go(6, 1'b0, 0);
		chk(n_pulse, 3);
		rc(REG_CMP_COUNT, 32'h1);
		wr(REG_CTRL, 32'h0);
		$display("test repeat done");
		load();
		rc(REG_ENC_POS, 32'h1b);
		rc(REG_CMP_CNTR, 32'h1b);
		n_pulse = 0;
		go(10, 1'b0, 0);
		chk(n_pulse, 0);
		wr(REG_CTRL, 32'h0);
		go(64, 1'b1, 0);
		rc(REG_ENC_POS, 32'h0);
		load();
		go(24, 1'b0, 0);
		chk(n_pulse, 2);
		$display("test load done");
		wr(REG_CTRL, 32'h0);
		n_nvm = 0;
		wr(REG_NVM_CMD, 32'h1);
		repeat (4) @(posedge clk);
		chk(n_nvm, 1);
		wr(REG_CTRL, 32'h0002_0001);
		wr(REG_NVM_CMD, 32'h1);
		repeat (4) @(posedge clk);
		chk(n_nvm, 1);
		rc(REG_STATUS, 32'h2);
		$display("test store done");
		wrap_up();
	end
endmodule
